/* File: shared/imcb_pkg.sv */
package imcb_pkg;

  // register byte offsets, one aligned 32-bit word each
  localparam logic [4:0] OFS_RELOAD = 5'h00;
  localparam logic [4:0] OFS_BUFFER = 5'h04;
  localparam logic [4:0] OFS_CTRL1  = 5'h08;
  localparam logic [4:0] OFS_CTRL2  = 5'h0C;
  localparam logic [4:0] OFS_FLAGS  = 5'h10;
  localparam logic [4:0] OFS_ENABLE = 5'h14;
  localparam logic [4:0] OFS_STATUS = 5'h18;

  // serial_control_1 fields
  localparam int unsigned CTRL1_PORT_EN = 5;

  // serial_control_2 request fields
  localparam int unsigned CTRL2_START   = 0;
  localparam int unsigned CTRL2_RESTART = 1;
  localparam int unsigned CTRL2_STOP    = 2;

  // flag and enable layout
  localparam int unsigned FLAG_PORT_EVENT = 0;
  localparam int unsigned FLAG_COLLISION  = 1;

  // status fields
  localparam int unsigned STAT_SDA  = 0;
  localparam int unsigned STAT_SCL  = 1;
  localparam int unsigned STAT_BUSY = 2;

  // reset values
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [7:0] BUFFER_RST = 8'h00;
  localparam logic [2:0] REQ_RST    = 3'h0;
  localparam logic [1:0] FLAGS_RST  = 2'h0;

  // half periods of the bus clock for one buffer-started transfer
  localparam int unsigned XFER_EDGES = 16;

  typedef enum logic [3:0] {
    IMCB_IDLE,
    IMCB_ST_CNT1,
    IMCB_ST_CNT2,
    IMCB_RS_CNT1,
    IMCB_RS_SCLW,
    IMCB_RS_CNT2,
    IMCB_RS_CNT3,
    IMCB_SP_SDAW,
    IMCB_SP_SCLW,
    IMCB_SP_CNT1,
    IMCB_SP_CNT2,
    IMCB_XFER
  } imcb_state_t;

endpackage

/* File: rtl/imcb_top.sv */
`timescale 1ns/10ps
// Function
// - start checks both lines first; either low aborts, flags collision, goes idle
// - during first start count, low clock while data high is a collision
// - data seen low during first start count resets counter, drives data early
// - data high through first start count: drive data low, reload, count again
// - second start count ignores low clock; at its end drive clock low
// - restart releases data, counts, releases clock; data low on clock high collides
// - restart with both high reloads counter; falling data is no collision
// - restart clock falling before expiry, data not yet driven, is a collision
// - both high at restart expiry: drive data low, count, then drive clock low
// - stop drives data low, releases clock on data low, counts on clock high
// - stop: after expiry with data released, data low is a collision
// - stop: clock sampled low before data released is a collision
// - counter serves both modes, reloads from register, starts on buffer write
// - after an operation the counter stops and the clock line holds its state
// - counter reloads twice per generated bus clock period
// - bus clock is clock rate over two times (reload plus one)
// - collision aborts the condition, releases both lines, clears all request bits
// - any collision sets the collision flag and returns the port to idle
module imcb_top #(
  parameter int unsigned RELOAD_W   = 8,
  parameter int unsigned XFER_EDGES = imcb_pkg::XFER_EDGES
) (
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE,
  input  wire logic        SCL_IN,
  output logic             SCL_OUT,
  output logic             SCL_OE,
  output logic             IRQ
);

  function automatic logic hit(input logic [4:0] addr,
                               input logic [4:0] ofs);
    hit = (addr[4:2] == ofs[4:2]);
  endfunction

  // pin synchronisers
  logic                sda_meta;
  logic                sda_s;
  logic                scl_meta;
  logic                scl_s;

  // bus slave
  logic                wait_r;
  logic                next_wait;
  logic [31:0]         rdata;
  logic [31:0]         next_rdata;
  logic                wr_go;
  logic                lane0;

  // registers
  logic [RELOAD_W-1:0] reload;
  logic [RELOAD_W-1:0] next_reload;
  logic [7:0]          buffer;
  logic [7:0]          next_buffer;
  logic                port_en;
  logic                next_port_en;
  logic [2:0]          req;
  logic [2:0]          next_req;
  logic [1:0]          flags;
  logic [1:0]          next_flags;
  logic [1:0]          irq_en;
  logic [1:0]          next_irq_en;
  logic                irq_r;
  logic                next_irq;
  logic                buf_wr;

  // sequencer
  imcb_pkg::imcb_state_t state;
  imcb_pkg::imcb_state_t next_state;
  logic [RELOAD_W-1:0] cnt;
  logic [RELOAD_W-1:0] next_cnt;
  logic [4:0]          edges;
  logic [4:0]          next_edges;
  logic                sda_oe_r;
  logic                next_sda_oe;
  logic                scl_oe_r;
  logic                next_scl_oe;
  logic [2:0]          clr_req;
  logic                set_event;
  logic                set_coll;
  logic                cnt_zero;
  logic                counting;

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sda_meta <= 1'b1;
      sda_s    <= 1'b1;
      scl_meta <= 1'b1;
      scl_s    <= 1'b1;
    end else begin
      sda_meta <= SDA_IN;
      sda_s    <= sda_meta;
      scl_meta <= SCL_IN;
      scl_s    <= scl_meta;
    end
  end

  // one wait cycle on every access; read data is ready when it drops
  always_comb begin
    next_wait  = ~((AVS_READ | AVS_WRITE) & wait_r);
    next_rdata = rdata;
    if (AVS_READ & wait_r) begin
      next_rdata = 32'h0000_0000;
      if (hit(AVS_ADDRESS, imcb_pkg::OFS_RELOAD)) begin
        next_rdata[RELOAD_W-1:0] = reload;
      end else if (hit(AVS_ADDRESS, imcb_pkg::OFS_BUFFER)) begin
        next_rdata[7:0] = buffer;
      end else if (hit(AVS_ADDRESS, imcb_pkg::OFS_CTRL1)) begin
        next_rdata[imcb_pkg::CTRL1_PORT_EN] = port_en;
      end else if (hit(AVS_ADDRESS, imcb_pkg::OFS_CTRL2)) begin
        next_rdata[2:0] = req;
      end else if (hit(AVS_ADDRESS, imcb_pkg::OFS_FLAGS)) begin
        next_rdata[1:0] = flags;
      end else if (hit(AVS_ADDRESS, imcb_pkg::OFS_ENABLE)) begin
        next_rdata[1:0] = irq_en;
      end else if (hit(AVS_ADDRESS, imcb_pkg::OFS_STATUS)) begin
        next_rdata[imcb_pkg::STAT_SDA]  = sda_s;
        next_rdata[imcb_pkg::STAT_SCL]  = scl_s;
        next_rdata[imcb_pkg::STAT_BUSY] = (state != imcb_pkg::IMCB_IDLE);
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wait_r <= 1'b1;
      rdata  <= 32'h0000_0000;
    end else begin
      wait_r <= next_wait;
      rdata  <= next_rdata;
    end
  end

  assign wr_go  = AVS_WRITE & ~wait_r;
  assign lane0  = AVS_BYTEENABLE[0];
  assign buf_wr = wr_go & lane0 & hit(AVS_ADDRESS, imcb_pkg::OFS_BUFFER);

  // register file; hardware set beats a software clear in the same cycle
  always_comb begin
    next_reload  = reload;
    next_buffer  = buffer;
    next_port_en = port_en;
    next_req     = req & ~clr_req;
    next_irq_en  = irq_en;
    next_flags   = flags;
    if (wr_go & lane0) begin
      if (hit(AVS_ADDRESS, imcb_pkg::OFS_RELOAD)) begin
        next_reload = AVS_WRITEDATA[RELOAD_W-1:0];
      end else if (hit(AVS_ADDRESS, imcb_pkg::OFS_BUFFER)) begin
        next_buffer = AVS_WRITEDATA[7:0];
      end else if (hit(AVS_ADDRESS, imcb_pkg::OFS_CTRL1)) begin
        next_port_en = AVS_WRITEDATA[imcb_pkg::CTRL1_PORT_EN];
      end else if (hit(AVS_ADDRESS, imcb_pkg::OFS_CTRL2)) begin
        next_req = req | AVS_WRITEDATA[2:0];
      end else if (hit(AVS_ADDRESS, imcb_pkg::OFS_FLAGS)) begin
        next_flags = flags & ~AVS_WRITEDATA[1:0];
      end else if (hit(AVS_ADDRESS, imcb_pkg::OFS_ENABLE)) begin
        next_irq_en = AVS_WRITEDATA[1:0];
      end
    end
    if (!port_en) begin
      next_req = imcb_pkg::REQ_RST;
    end
    if (set_event) begin
      next_flags[imcb_pkg::FLAG_PORT_EVENT] = 1'b1;
    end
    if (set_coll) begin
      next_flags[imcb_pkg::FLAG_COLLISION] = 1'b1;
    end
    next_irq = |(flags & irq_en);
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      reload  <= imcb_pkg::RELOAD_RST;
      buffer  <= imcb_pkg::BUFFER_RST;
      port_en <= 1'b0;
      req     <= imcb_pkg::REQ_RST;
      flags   <= imcb_pkg::FLAGS_RST;
      irq_en  <= imcb_pkg::FLAGS_RST;
      irq_r   <= 1'b0;
    end else begin
      reload  <= next_reload;
      buffer  <= next_buffer;
      port_en <= next_port_en;
      req     <= next_req;
      flags   <= next_flags;
      irq_en  <= next_irq_en;
      irq_r   <= next_irq;
    end
  end

  // a count runs reload+1 cycles, one half period of the bus clock
  assign cnt_zero = (cnt == '0);
  assign counting = (state != imcb_pkg::IMCB_IDLE) &&
                    (state != imcb_pkg::IMCB_RS_SCLW) &&
                    (state != imcb_pkg::IMCB_SP_SDAW) &&
                    (state != imcb_pkg::IMCB_SP_SCLW);

  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_edges  = edges;
    next_sda_oe = sda_oe_r;
    next_scl_oe = scl_oe_r;
    clr_req     = 3'h0;
    set_event   = 1'b0;
    set_coll    = 1'b0;
    if (counting && !cnt_zero) begin
      next_cnt = cnt - 1'b1;
    end
    case (state)
      imcb_pkg::IMCB_IDLE: begin
        // counter frozen, lines keep their last drive
        if (req[imcb_pkg::CTRL2_START]) begin
          if (!sda_s || !scl_s) begin
            set_coll = 1'b1;
            clr_req[imcb_pkg::CTRL2_START] = 1'b1;
          end else begin
            next_cnt    = reload;
            next_sda_oe = 1'b0;
            next_scl_oe = 1'b0;
            next_state  = imcb_pkg::IMCB_ST_CNT1;
          end
        end else if (req[imcb_pkg::CTRL2_RESTART]) begin
          next_cnt    = reload;
          next_sda_oe = 1'b0;
          next_state  = imcb_pkg::IMCB_RS_CNT1;
        end else if (req[imcb_pkg::CTRL2_STOP]) begin
          next_sda_oe = 1'b1;
          next_state  = imcb_pkg::IMCB_SP_SDAW;
        end else if (buf_wr) begin
          next_cnt   = reload;
          next_edges = 5'(XFER_EDGES - 1);
          next_state = imcb_pkg::IMCB_XFER;
        end
      end
      imcb_pkg::IMCB_ST_CNT1: begin
        if (!scl_s && sda_s) begin
          set_coll = 1'b1;
        end else if (!sda_s) begin
          next_cnt    = reload;
          next_sda_oe = 1'b1;
          next_state  = imcb_pkg::IMCB_ST_CNT2;
        end else if (cnt_zero) begin
          next_cnt    = reload;
          next_sda_oe = 1'b1;
          next_state  = imcb_pkg::IMCB_ST_CNT2;
        end
      end
      imcb_pkg::IMCB_ST_CNT2: begin
        // a low clock here is another master's start, not a collision
        if (cnt_zero) begin
          next_scl_oe = 1'b1;
          set_event   = 1'b1;
          clr_req[imcb_pkg::CTRL2_START] = 1'b1;
          next_state  = imcb_pkg::IMCB_IDLE;
        end
      end
      imcb_pkg::IMCB_RS_CNT1: begin
        if (cnt_zero) begin
          next_scl_oe = 1'b0;
          next_state  = imcb_pkg::IMCB_RS_SCLW;
        end
      end
      imcb_pkg::IMCB_RS_SCLW: begin
        if (scl_s) begin
          if (!sda_s) begin
            set_coll = 1'b1;
          end else begin
            next_cnt   = reload;
            next_state = imcb_pkg::IMCB_RS_CNT2;
          end
        end
      end
      imcb_pkg::IMCB_RS_CNT2: begin
        // data falling here is another master's restart
        if (!scl_s) begin
          set_coll = 1'b1;
        end else if (cnt_zero) begin
          next_sda_oe = 1'b1;
          next_cnt    = reload;
          next_state  = imcb_pkg::IMCB_RS_CNT3;
        end
      end
      imcb_pkg::IMCB_RS_CNT3: begin
        if (cnt_zero) begin
          next_scl_oe = 1'b1;
          set_event   = 1'b1;
          clr_req[imcb_pkg::CTRL2_RESTART] = 1'b1;
          next_state  = imcb_pkg::IMCB_IDLE;
        end
      end
      imcb_pkg::IMCB_SP_SDAW: begin
        if (!sda_s) begin
          next_scl_oe = 1'b0;
          next_state  = imcb_pkg::IMCB_SP_SCLW;
        end
      end
      imcb_pkg::IMCB_SP_SCLW: begin
        if (scl_s) begin
          next_cnt   = reload;
          next_state = imcb_pkg::IMCB_SP_CNT1;
        end
      end
      imcb_pkg::IMCB_SP_CNT1: begin
        if (!scl_s) begin
          set_coll = 1'b1;
        end else if (cnt_zero) begin
          next_sda_oe = 1'b0;
          next_cnt    = reload;
          next_state  = imcb_pkg::IMCB_SP_CNT2;
        end
      end
      imcb_pkg::IMCB_SP_CNT2: begin
        if (cnt_zero) begin
          if (!sda_s) begin
            set_coll = 1'b1;
          end else begin
            set_event  = 1'b1;
            clr_req[imcb_pkg::CTRL2_STOP] = 1'b1;
            next_state = imcb_pkg::IMCB_IDLE;
          end
        end
      end
      imcb_pkg::IMCB_XFER: begin
        // clock only; data shifting lives elsewhere
        if (cnt_zero) begin
          next_scl_oe = ~scl_oe_r;
          if (edges == 5'h00) begin
            set_event  = 1'b1;
            next_state = imcb_pkg::IMCB_IDLE;
          end else begin
            next_cnt   = reload;
            next_edges = edges - 1'b1;
          end
        end
      end
      default: begin
        next_state = imcb_pkg::IMCB_IDLE;
      end
    endcase
    if (set_coll) begin
      next_sda_oe = 1'b0;
      next_scl_oe = 1'b0;
      clr_req     = 3'h7;
      next_state  = imcb_pkg::IMCB_IDLE;
    end
    if (!port_en) begin
      next_sda_oe = 1'b0;
      next_scl_oe = 1'b0;
      next_state  = imcb_pkg::IMCB_IDLE;
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state    <= imcb_pkg::IMCB_IDLE;
      cnt      <= '0;
      edges    <= 5'h00;
      sda_oe_r <= 1'b0;
      scl_oe_r <= 1'b0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      edges    <= next_edges;
      sda_oe_r <= next_sda_oe;
      scl_oe_r <= next_scl_oe;
    end
  end

  // open drain: only ever drive low
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      SDA_OUT <= 1'b0;
      SCL_OUT <= 1'b0;
    end else begin
      SDA_OUT <= 1'b0;
      SCL_OUT <= 1'b0;
    end
  end

  assign SDA_OE          = sda_oe_r;
  assign SCL_OE          = scl_oe_r;
  assign IRQ             = irq_r;
  assign AVS_READDATA    = rdata;
  assign AVS_WAITREQUEST = wait_r;

endmodule

/* File: testbench/imcb_bus_model.sv */
`timescale 1ns/10ps
// other masters and slaves on the shared bus, both lines pulled up
module imcb_bus_model (
  input  wire logic       clk,
  input  wire logic       dut_sda_oe,
  input  wire logic       dut_scl_oe,
  input  wire logic       hold_sda,
  input  wire logic       hold_scl,
  input  wire logic [3:0] stretch,
  output logic            sda,
  output logic            scl
);
  logic [3:0] st_cnt = 4'h0;
  logic       scl_oe_q = 1'b0;
  logic       stretching;

  // a slow slave keeps the clock low for a while after the master lets go
  always_ff @(posedge clk) begin
    scl_oe_q <= dut_scl_oe;
    if (scl_oe_q && !dut_scl_oe)
      st_cnt <= stretch;
    else if (st_cnt != 4'h0)
      st_cnt <= st_cnt - 4'h1;
  end
  // covers the edge before the count loads, so no glitch high
  assign stretching = st_cnt != 4'h0 || (scl_oe_q && stretch != 4'h0);
  assign sda = !(dut_sda_oe || hold_sda);
  assign scl = !(dut_scl_oe || hold_scl || stretching);
endmodule

/* File: testbench/imcb_assertions.sv */
`timescale 1ns/10ps
module imcb_assertions (
  input wire logic        SYS_CLK,
  input wire logic        SYS_RST,
  input wire logic [4:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        SDA_IN,
  input wire logic        SDA_OUT,
  input wire logic        SDA_OE,
  input wire logic        SCL_IN,
  input wire logic        SCL_OUT,
  input wire logic        SCL_OE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  logic [7:0] reload;
  logic [9:0] cnt;
  logic       sda_q, scl_q, last_scl, last_sda;
  logic       tk;
  logic [9:0] half;
  assign tk = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
  assign half = {2'h0, reload} + 10'h001;

  // cnt: cycles since the last change of either enable
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      reload <= imcb_pkg::RELOAD_RST;
      cnt <= 10'h000;
      sda_q <= 1'b0;
      scl_q <= 1'b0;
      last_scl <= 1'b0;
      last_sda <= 1'b0;
    end else begin
      sda_q <= SDA_OE;
      scl_q <= SCL_OE;
      if (tk && AVS_ADDRESS == imcb_pkg::OFS_RELOAD)
        reload <= AVS_WRITEDATA[7:0];
      if (sda_q != SDA_OE || scl_q != SCL_OE) begin
        cnt <= 10'h001;
        last_scl <= sda_q == SDA_OE && !SDA_OE;
        last_sda <= scl_q == SCL_OE && SDA_OE;
      end else if (cnt != 10'h3FF)
        cnt <= cnt + 10'h001;
      // a new command restarts the spacing history
      if (tk && (AVS_ADDRESS == imcb_pkg::OFS_BUFFER ||
                 AVS_ADDRESS == imcb_pkg::OFS_CTRL2))
        last_scl <= 1'b0;
    end
  end

  sequence s_wr_start;
    tk && AVS_ADDRESS == imcb_pkg::OFS_CTRL2 && AVS_WRITEDATA[0];
  endsequence
  sequence s_scl_edge;
    scl_q != SCL_OE;
  endsequence

  a_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
    |=> !AVS_WAITREQUEST) else $error("access not answered next cycle");
  a_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low longer than one cycle");
  a_open_drain: assert property (!SDA_OUT && !SCL_OUT)
    else $error("line output driven high");
  a_start_abort: assert property (s_wr_start ##0 (!SCL_IN
    && !$past(SCL_IN, 3) && !SDA_OE && !SCL_OE) |=> (!SDA_OE && !SCL_OE) [*8])
    else $error("start went ahead with the clock line low");
  a_scl_half: assert property (s_scl_edge ##0 (!SDA_OE && last_scl)
    |-> cnt == half) else $error("clock half period wrong");
  a_scl_after_sda: assert property (s_scl_edge ##0 (SCL_OE && SDA_OE
    && sda_q && last_sda) |-> cnt == half)
    else $error("clock driven low at the wrong time after data");
  a_stop_release: assert property ($fell(SCL_OE) && SDA_OE
    && $past(SDA_OE, 2) |-> !$past(SDA_IN, 2))
    else $error("clock released before data seen low");
  a_restart_release: assert property ($fell(SCL_OE) && !SDA_OE
    && !$past(SDA_OE, 2) && !last_scl |-> $past(SDA_IN, 2))
    else $error("clock released before data seen high");
endmodule

bind imcb_top imcb_assertions u_chk (.SYS_CLK, .SYS_RST, .AVS_ADDRESS,
  .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_WAITREQUEST,
  .SDA_IN, .SDA_OUT, .SDA_OE, .SCL_IN, .SCL_OUT, .SCL_OE);

/* File: testbench/imcb_test.sv */
`timescale 1ns/10ps
module imcb_test;
  localparam logic [7:0] RQ_S = 8'h01 << imcb_pkg::CTRL2_START;
  localparam logic [7:0] RQ_R = 8'h01 << imcb_pkg::CTRL2_RESTART;
  localparam logic [7:0] RQ_P = 8'h01 << imcb_pkg::CTRL2_STOP;
  localparam logic [7:0] EV   = 8'h01 << imcb_pkg::FLAG_PORT_EVENT;
  localparam logic [7:0] COL  = 8'h01 << imcb_pkg::FLAG_COLLISION;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  adr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, v;
  logic        wait_r, sda, scl, sda_oe, scl_oe, irq;
  logic        hold_sda = 1'b0;
  logic        hold_scl = 1'b0;
  logic [3:0]  stretch = 4'h0;
  logic        scl_oe_q = 1'b0;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          tog = 0;
  logic [7:0]  col_req [3] = '{RQ_R, RQ_P, RQ_P};
  logic        col_sda [3] = '{1'b0, 1'b0, 1'b1};

  always #10 clk = ~clk;
  always @(posedge clk) begin
    scl_oe_q <= scl_oe;
    if (scl_oe_q !== scl_oe) tog++;
  end

  imcb_top uut (.SYS_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
    .AVS_BYTEENABLE(4'h1), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_r),
    .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe), .SCL_IN(scl), .SCL_OUT(),
    .SCL_OE(scl_oe), .IRQ(irq));
  imcb_bus_model bus (.clk(clk), .dut_sda_oe(sda_oe), .dut_scl_oe(scl_oe),
    .hold_sda(hold_sda), .hold_scl(hold_scl), .stretch(stretch),
    .sda(sda), .scl(scl));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // request held until waitrequest is sampled low
  task automatic bus_op(input logic w, input logic [4:0] a,
                        input logic [7:0] d);
    int n;
    n = 0;
    adr <= a;
    wdat <= {24'h0, d};
    rd <= !w;
    wr <= w;
    // look between edges so the flop updates of an edge never race the check
    do begin
      @(negedge clk);
      n++;
    end while (wait_r !== 1'b0 && n < 50);
    if (n >= 50) error_cnt++;
    v = rdat;
    @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e,
                        input string what);
    bus_op(1'b0, a, 8'h00);
    chk(v, {24'h0, e}, what);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      bus_op(1'b0, imcb_pkg::OFS_STATUS, 8'h00);
      n++;
    end while (v[imcb_pkg::STAT_BUSY] !== 1'b0 && n < 200);
  endtask

  // pull > 0: another party pulls a line low that many cycles after
  // the device lets that line go
  task automatic cond(input logic [7:0] req, input logic [7:0] fl,
                      input int pull, input logic on_sda);
    int n;
    n = 0;
    bus_op(1'b1, imcb_pkg::OFS_CTRL2, req);
    if (pull > 0) begin
      while ((on_sda ? sda_oe : scl_oe) !== 1'b0 && n < 300) begin
        @(posedge clk);
        n++;
      end
      repeat (pull) @(posedge clk);
      if (on_sda) hold_sda <= 1'b1;
      else hold_scl <= 1'b1;
    end
    wait_idle();
    chk(irq, 1'b1, "irq");
    rd_chk(imcb_pkg::OFS_FLAGS, fl, "flags");
    rd_chk(imcb_pkg::OFS_CTRL2, 8'h00, "requests");
    hold_sda <= 1'b0;
    hold_scl <= 1'b0;
    bus_op(1'b1, imcb_pkg::OFS_FLAGS, 8'h03);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #1000000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(imcb_pkg::OFS_RELOAD, imcb_pkg::RELOAD_RST, "reload reset");
    rd_chk(imcb_pkg::OFS_FLAGS, 8'h00, "flags reset");
    bus_op(1'b1, imcb_pkg::OFS_RELOAD, 8'h09);
    rd_chk(imcb_pkg::OFS_RELOAD, 8'h09, "reload");
    bus_op(1'b1, 5'h1C, 8'hFF);
    rd_chk(5'h1C, 8'h00, "unmapped");
    bus_op(1'b1, imcb_pkg::OFS_CTRL1, 8'h01 << imcb_pkg::CTRL1_PORT_EN);
    bus_op(1'b1, imcb_pkg::OFS_ENABLE, EV | COL);
    cond(RQ_S, EV, 6, 1'b1);
    chk({sda_oe, scl_oe}, 2'b11, "start lines");
    tog = 0;
    bus_op(1'b1, imcb_pkg::OFS_BUFFER, 8'hA5);
    wait_idle();
    chk(tog, imcb_pkg::XFER_EDGES, "clock edges");
    repeat (20) @(posedge clk);
    chk(tog, imcb_pkg::XFER_EDGES, "clock held");
    chk(scl_oe, 1'b1, "clock state");
    bus_op(1'b1, imcb_pkg::OFS_ENABLE, COL);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0, "masked irq");
    bus_op(1'b1, imcb_pkg::OFS_ENABLE, EV | COL);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1, "unmasked irq");
    bus_op(1'b1, imcb_pkg::OFS_FLAGS, 8'h03);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0, "cleared irq");
    rd_chk(imcb_pkg::OFS_FLAGS, 8'h00, "cleared flags");
    stretch <= 4'h5;
    cond(RQ_R, EV, 0, 1'b0);
    chk({sda_oe, scl_oe}, 2'b11, "restart lines");
    cond(RQ_P, EV, 0, 1'b0);
    chk({sda_oe, scl_oe}, 2'b00, "stop lines");
    stretch <= 4'h0;
    hold_scl <= 1'b1;
    repeat (4) @(posedge clk);
    cond(RQ_S, COL, 0, 1'b0);
    chk({sda_oe, scl_oe}, 2'b00, "abort lines");
    cond(RQ_S, COL, 4, 1'b0);
    chk({sda_oe, scl_oe}, 2'b00, "start collision lines");
    for (int i = 0; i < 3; i++) begin
      cond(RQ_S, EV, 0, 1'b0);
      cond(col_req[i], COL, 4, col_sda[i]);
      chk({sda_oe, scl_oe}, 2'b00, "collision lines");
    end
    tally_and_finish();
  end
endmodule
